// [design/bfpd_pkg.sv]
package bfpd_pkg;
  // Memory-size variants
  localparam int VAR_64K  = 0;
  localparam int VAR_128K = 1;

  // Page geometry
  localparam int PAGE_WORDS_W = 7;
  localparam int PC_W_64K     = 16;
  localparam int PC_W_128K    = 17;
  localparam int PC_W_MAX     = 17;
  localparam int PAGE_W_MAX   = PC_W_MAX - PAGE_WORDS_W;

  // Boot start word addresses, 64K-word variant
  localparam logic [16:0] BOOT64_SZ3 = 17'h0FE00;
  localparam logic [16:0] BOOT64_SZ2 = 17'h0FC00;
  localparam logic [16:0] BOOT64_SZ1 = 17'h0F800;
  localparam logic [16:0] BOOT64_SZ0 = 17'h0F000;
  // Boot start word addresses, 128K-word variant
  localparam logic [16:0] BOOT128_SZ3 = 17'h1FE00;
  localparam logic [16:0] BOOT128_SZ2 = 17'h1FC00;
  localparam logic [16:0] BOOT128_SZ1 = 17'h1F800;
  localparam logic [16:0] BOOT128_SZ0 = 17'h1F000;
  // First word of the no-read-while-write region
  localparam logic [16:0] NRWW64_START  = 17'h0F000;
  localparam logic [16:0] NRWW128_START = 17'h1F000;

  // Self-programming command patterns, low five bits
  localparam logic [4:0] CMD_FILL  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  // AHB-Lite register offsets (byte addresses)
  localparam logic [7:0] REG_POINTER  = 8'h00;
  localparam logic [7:0] REG_EXT      = 8'h04;
  localparam logic [7:0] REG_CMD      = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0C;
  localparam logic [7:0] REG_DECODE   = 8'h10;
  localparam int         REG_ADDR_W   = 8;

  // Status bit positions
  localparam int ST_BUSY   = 0;
  localparam int ST_BOOT   = 1;
  localparam int ST_NO_READ_WHILE_WRITE_REGION   = 2;
  localparam int ST_ARMED  = 3;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  // Decoded flash address
  typedef struct packed {
    logic [PAGE_W_MAX-1:0]   page_select;
    logic [PAGE_WORDS_W-1:0] word_select;
    logic                    byte_high;
    logic                    in_boot;
    logic                    in_no_read_while_write_region;
  } bfpd_addr_t;

  // AHB-Lite request
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
  } bfpd_ahb_req_t;

  // Command states
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_ARMED_S = 2'b01,
    ST_PROG   = 2'b10
  } bfpd_state_t;
endpackage

// [design/bfpd_decode.sv]
`timescale 1ns/10ps
`default_nettype none
// Pure address decode: pointer to page/word and region flags
module bfpd_decode #(
  parameter int VARIANT = 0
) (
  input  wire logic [1:0]     i_boot_size_select,
  input  wire logic [15:0]    i_pointer,
  input  wire logic [1:0]     i_pointer_ext,
  output bfpd_pkg::bfpd_addr_t o_addr
);
  import bfpd_pkg::*;

  localparam int PC_W = (VARIANT == VAR_128K) ? PC_W_128K : PC_W_64K;

  if (VARIANT != VAR_64K && VARIANT != VAR_128K) begin : g_bad_variant
    $error("bfpd_decode: unsupported VARIANT");
  end

  // Boot start lookup, one table per variant
  function automatic logic [16:0] boot_start(input logic [1:0] sz);
    logic [16:0] r;
    r = '0;
    if (VARIANT == VAR_128K) begin
      case (sz)
        2'h3:    r = BOOT128_SZ3;
        2'h2:    r = BOOT128_SZ2;
        2'h1:    r = BOOT128_SZ1;
        default: r = BOOT128_SZ0;
      endcase
    end else begin
      case (sz)
        2'h3:    r = BOOT64_SZ3;
        2'h2:    r = BOOT64_SZ2;
        2'h1:    r = BOOT64_SZ1;
        default: r = BOOT64_SZ0;
      endcase
    end
    return r;
  endfunction

  // Full pointer with extension; bit 0 is the byte select
  wire logic [16:0] pc_full;
  wire logic [16:0] pc;
  wire logic [16:0] no_read_while_write_region_start;
  wire logic [16:0] page_base;

  assign pc_full    = {i_pointer_ext, i_pointer[15:1]};
  // 64K variant has 16 PC bits, so the top bit is forced low
  assign pc         = (PC_W == PC_W_128K) ? pc_full
                                          : {1'b0, pc_full[15:0]};
  assign no_read_while_write_region_start = (VARIANT == VAR_128K) ? NRWW128_START
                                            : NRWW64_START;
  assign page_base  = {pc[16:PAGE_WORDS_W], {PAGE_WORDS_W{1'b0}}};

  // Page/word split and region compare
  assign o_addr.page_select = pc[16:PAGE_WORDS_W];
  assign o_addr.word_select = pc[PAGE_WORDS_W-1:0];
  assign o_addr.byte_high   = i_pointer[0];
  assign o_addr.in_boot     = page_base >= boot_start(i_boot_size_select);
  assign o_addr.in_no_read_while_write_region     = page_base >= no_read_while_write_region_start;
endmodule
`default_nettype wire

// [design/bfpd_top.sv]
// Register access over AHB-Lite and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - 64K variant: boot size select gives boot start FE00/FC00/F800/F000.
// - 128K variant: boot start 1FE00/1FC00/1F800/1F000, top of flash.
// - 64K variant: words 0x0000-0xEFFF are read-while-write region.
// - 64K variant: words 0xF000-0xFFFF are no-read-while-write region.
// - 128K variant: words 0x00000-0x1EFFF are read-while-write region.
// - 128K variant: words 0x1F000-0x1FFFF are no-read-while-write region.
// - Pages hold 128 words; PC bits 6:0 select the word.
// - 64K variant: 16-bit PC, bits 15:7 are page select.
// - 128K variant: 17-bit PC, bits 16:7 from pointer bits 17:8.
// - Pointer bits 7:1 select buffer word; zero during page write.
// - Pointer bit 0 zero for stores; byte select for program loads.
// - PC bit n comes from pointer bit n+1.
// - Pointer is 16 bits; bit 16 comes from extension register.
// - Only five listed command patterns accepted; others ignored.
// - Erase or write to read-while-write region sets busy flag.
module bfpd_top #(
  parameter int VARIANT   = 0,
  parameter int PROG_CYC  = 8
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_ce,
  input  wire logic [1:0]             i_boot_size_select,
  input  wire logic                   i_hsel,
  input  wire logic [31:0]            i_haddr,
  input  wire logic [1:0]             i_htrans,
  input  wire logic                   i_hwrite,
  input  wire logic [2:0]             i_hsize,
  input  wire logic [31:0]            i_hwdata,
  input  wire logic                   i_hready,
  input  wire logic                   i_store_program,
  input  wire logic                   i_load_program_instruction,
  input  wire logic                   i_rww_access,
  output logic [31:0]                 o_hrdata,
  output logic                        o_hreadyout,
  output logic                        o_hresp,
  output logic [bfpd_pkg::PAGE_W_MAX-1:0]   o_page_select,
  output logic [bfpd_pkg::PAGE_WORDS_W-1:0] o_word_select,
  output logic                        o_byte_high,
  output logic                        o_in_boot,
  output logic                        o_in_no_read_while_write_region,
  output logic                        o_region_busy_flag,
  output logic                        o_rww_blocked,
  output logic                        o_erase_stb,
  output logic                        o_write_stb,
  output logic                        o_fill_stb,
  output logic                        o_lock_stb
);
  import bfpd_pkg::*;

  // Store must follow the command write within this many cycles
  localparam int ARM_CYC = 4;
  localparam int CNT_W   = 16;

  // Refuse parameter values the counter and decode cannot serve
  if (PROG_CYC < 1 || PROG_CYC > (2 ** CNT_W) - 1) begin : g_bad_prog_cyc
    $error("bfpd_top: PROG_CYC out of range");
  end
  if (VARIANT != VAR_64K && VARIANT != VAR_128K) begin : g_bad_variant
    $error("bfpd_top: unsupported VARIANT");
  end

  // Boot size pins are static straps from outside: two-stage sync
  // Reset value 11 picks the smallest boot section until the strap settles
  logic [1:0] boot_meta_r;
  logic [1:0] boot_sync_r;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      boot_meta_r <= 2'h3;
      boot_sync_r <= 2'h3;
    end else if (i_ce) begin
      boot_meta_r <= i_boot_size_select;
      boot_sync_r <= boot_meta_r;
    end
  end

  // Software-visible registers
  logic [15:0]       pointer_r;
  logic [1:0]        ext_r;
  logic [4:0]        cmd_r;
  logic              busy_r;
  bfpd_state_t       state_r;
  logic [CNT_W-1:0]  cnt_r;

  // Address phase capture
  logic              dp_valid_r;
  logic              dp_write_r;
  logic [REG_ADDR_W-1:0] dp_addr_r;

  bfpd_addr_t dec;

  bfpd_decode #(
    .VARIANT (VARIANT)
  ) u_decode (
    .i_boot_size_select (boot_sync_r),
    .i_pointer          (pointer_r),
    .i_pointer_ext      (ext_r),
    .o_addr             (dec)
  );

  // Extension holds pointer bits 16 and 17; the small part has no bit 17,
  // so that bit is held at zero there
  localparam logic [1:0] EXT_MASK = (VARIANT == VAR_128K) ? 2'h3
                                                          : 2'h1;

  // Bus decode
  // Narrow or misaligned transfers fall outside take and are dropped
  wire logic addr_ok;
  wire logic take;
  wire logic wr_ptr;
  wire logic wr_ext;
  wire logic wr_cmd;
  assign addr_ok = (i_hsize == HSIZE_WORD) && (i_haddr[1:0] == 2'h0);
  assign take    = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ)
                   && addr_ok;
  assign wr_ptr  = dp_valid_r && dp_write_r && (dp_addr_r == REG_POINTER);
  assign wr_ext  = dp_valid_r && dp_write_r && (dp_addr_r == REG_EXT);
  assign wr_cmd  = dp_valid_r && dp_write_r && (dp_addr_r == REG_CMD);

  // Only the five legal patterns are accepted
  wire logic cmd_legal;
  assign cmd_legal = (i_hwdata[4:0] == CMD_FILL)
                  || (i_hwdata[4:0] == CMD_ERASE)
                  || (i_hwdata[4:0] == CMD_WRITE)
                  || (i_hwdata[4:0] == CMD_LOCK)
                  || (i_hwdata[4:0] == CMD_REEN);
  // A command cannot be re-armed while programming runs
  wire logic cmd_take;
  assign cmd_take = wr_cmd && cmd_legal && (state_r != ST_PROG);

  // Store instruction executes the armed command
  wire logic exec;
  wire logic exec_erase;
  wire logic exec_write;
  wire logic exec_fill;
  wire logic exec_lock;
  wire logic exec_reen;
  assign exec       = i_store_program && (state_r == ST_ARMED_S);
  assign exec_erase = exec && (cmd_r == CMD_ERASE);
  assign exec_write = exec && (cmd_r == CMD_WRITE);
  assign exec_fill  = exec && (cmd_r == CMD_FILL);
  assign exec_lock  = exec && (cmd_r == CMD_LOCK);
  assign exec_reen  = exec && (cmd_r == CMD_REEN);

  // Programming into rww region raises busy
  wire logic prog_start;
  wire logic prog_done;
  assign prog_start = exec_erase || exec_write;
  assign prog_done  = (state_r == ST_PROG) && (cnt_r == CNT_W'(1));

  // One counter serves as arming window and programming timer,
  // which keeps each state and its timeout in step
  // Sequencer next state
  bfpd_state_t       state_nxt;
  logic [CNT_W-1:0]  cnt_nxt;
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (cmd_take) begin
          state_nxt = ST_ARMED_S;
          cnt_nxt   = CNT_W'(ARM_CYC);
        end
      end
      ST_ARMED_S: begin
        if (prog_start) begin
          state_nxt = ST_PROG;
          cnt_nxt   = CNT_W'(PROG_CYC);
        end else if (exec) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end else if (cmd_take) begin
          cnt_nxt   = CNT_W'(ARM_CYC);
        end else if (cnt_r == CNT_W'(1)) begin
          // Arming window lapses without a store
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt   = cnt_r - CNT_W'(1);
        end
      end
      ST_PROG: begin
        if (prog_done) begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end else begin
          cnt_nxt   = cnt_r - CNT_W'(1);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  // Busy: set wins over any clear in the same cycle
  // Fill and reenable both release the region; reenable is ignored
  // mid-program because the array is still busy then
  wire logic busy_set;
  wire logic busy_clr;
  wire logic busy_nxt;
  assign busy_set = prog_start && !dec.in_no_read_while_write_region;
  assign busy_clr = exec_fill || (exec_reen && state_r != ST_PROG);
  assign busy_nxt = busy_set | (busy_r & ~busy_clr);

  // Sequencer state
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_r    <= ST_IDLE;
      cnt_r      <= '0;
      busy_r     <= 1'b0;
    end else if (i_ce) begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // Register writes
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pointer_r <= 16'h0000;
      ext_r     <= 2'h0;
      cmd_r     <= 5'h00;
    end else if (i_ce) begin
      if (wr_ptr)
        pointer_r <= i_hwdata[15:0];
      if (wr_ext)
        // Extension bits beyond the variant's address width stay zero
        ext_r <= i_hwdata[1:0] & EXT_MASK;
      if (cmd_take)
        cmd_r <= i_hwdata[4:0];
    end
  end

  // Address phase capture; slave is always ready
  // Capture holds while hready is low, so a stalled phase is kept
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      dp_valid_r <= 1'b0;
      dp_write_r <= 1'b0;
      dp_addr_r  <= '0;
    end else if (i_ce) begin
      if (i_hready) begin
        dp_valid_r <= take;
        dp_write_r <= i_hwrite;
        dp_addr_r  <= i_haddr[REG_ADDR_W-1:0];
      end
    end
  end

  // Read mux, unmapped addresses read zero
  // Status and decode are live views, so a read right after a pointer
  // write already shows the new page
  wire logic [31:0] status_word;
  wire logic [31:0] decode_word;
  logic      [31:0] rd_mux;
  assign status_word = {28'h0000000, (state_r == ST_ARMED_S),
                        dec.in_no_read_while_write_region, dec.in_boot, busy_r};
  assign decode_word = {14'h0000, dec.page_select, dec.word_select,
                        dec.byte_high};
  always_comb begin
    case (dp_addr_r)
      REG_POINTER: rd_mux = {16'h0000, pointer_r};
      REG_EXT:     rd_mux = {30'h00000000, ext_r};
      REG_CMD:     rd_mux = {27'h0000000, cmd_r};
      REG_STATUS:  rd_mux = status_word;
      REG_DECODE:  rd_mux = decode_word;
      default:     rd_mux = 32'h00000000;
    endcase
  end

  assign o_hrdata    = rd_mux;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  // Decoded address and flags to the flash array
  assign o_page_select = dec.page_select;
  assign o_word_select = dec.word_select;
  // Byte select matters only for program loads
  assign o_byte_high   = dec.byte_high & i_load_program_instruction;
  assign o_in_boot     = dec.in_boot;
  assign o_in_no_read_while_write_region     = dec.in_no_read_while_write_region;
  assign o_region_busy_flag = busy_r;
  assign o_rww_blocked = busy_r & i_rww_access;

  // One-cycle command strobes
  // Gated by the clock enable so a frozen block issues nothing
  assign o_erase_stb = exec_erase & i_ce;
  assign o_write_stb = exec_write & i_ce;
  assign o_fill_stb  = exec_fill & i_ce;
  assign o_lock_stb  = exec_lock & i_ce;
endmodule
`default_nettype wire

// [testbench/bfpd_top_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
// Port-level checks on the decode and the command strobes
module bfpd_top_asserts #(
  parameter int VARIANT  = 0,
  parameter int PROG_CYC = 8
) (
  input wire logic       i_clk,
  input wire logic       i_sys_rst,
  input wire logic       i_store_program,
  input wire logic       i_load_program_instruction,
  input wire logic       i_rww_access,
  input wire logic       o_hreadyout,
  input wire logic       o_hresp,
  input wire logic [9:0] o_page_select,
  input wire logic       o_byte_high,
  input wire logic       o_in_boot,
  input wire logic       o_in_no_read_while_write_region,
  input wire logic       o_region_busy_flag,
  input wire logic       o_rww_blocked,
  input wire logic       o_erase_stb,
  input wire logic       o_write_stb,
  input wire logic       o_fill_stb,
  input wire logic       o_lock_stb
);
  wire [3:0] stb = {o_erase_stb, o_write_stb, o_fill_stb, o_lock_stb};
  wire       prg = o_erase_stb || o_write_stb;
  // Region boundary as a page number, 32 pages below the top
  wire [9:0] no_read_while_write_region_pg = (VARIANT == 1) ? 10'h3E0 : 10'h1E0;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  bus_okay_a: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  no_read_while_write_region_bound_a: assert property (o_in_no_read_while_write_region == (o_page_select >= no_read_while_write_region_pg))
    else $error("no-rww flag disagrees with page");
  boot_inside_a: assert property (o_in_boot |-> o_in_no_read_while_write_region)
    else $error("boot flag outside no-rww region");
  page_top_a: assert property (VARIANT == 0 |-> !o_page_select[9])
    else $error("page top bit set in small variant");
  byte_sel_a: assert property (!i_load_program_instruction |-> !o_byte_high)
    else $error("byte select without program load");
  stb_cause_a: assert property (stb != 4'h0 |-> i_store_program && $onehot(stb))
    else $error("strobe without single store");
  stb_pulse_a: assert property (stb != 4'h0 |=> stb == 4'h0)
    else $error("strobe longer than one cycle");
  busy_set_a: assert property (prg && !o_in_no_read_while_write_region |=> o_region_busy_flag)
    else $error("busy not set by rww programming");
  busy_no_read_while_write_region_a: assert property (prg && o_in_no_read_while_write_region && !o_region_busy_flag
    |=> !o_region_busy_flag)
    else $error("busy set by no-rww programming");
  busy_hold_a: assert property (o_region_busy_flag && !i_store_program
    |=> o_region_busy_flag)
    else $error("busy dropped without a store");
  rww_block_a: assert property (o_rww_blocked ==
    (o_region_busy_flag && i_rww_access))
    else $error("rww block disagrees with busy");
endmodule
bind bfpd_top bfpd_top_asserts #(.VARIANT(VARIANT), .PROG_CYC(PROG_CYC))
  bfpd_top_asserts_i (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_store_program(i_store_program),
  .i_load_program_instruction(i_load_program_instruction),
  .i_rww_access(i_rww_access), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_page_select(o_page_select),
  .o_byte_high(o_byte_high), .o_in_boot(o_in_boot),
  .o_in_no_read_while_write_region(o_in_no_read_while_write_region), .o_region_busy_flag(o_region_busy_flag),
  .o_rww_blocked(o_rww_blocked), .o_erase_stb(o_erase_stb),
  .o_write_stb(o_write_stb), .o_fill_stb(o_fill_stb),
  .o_lock_stb(o_lock_stb));
`default_nettype wire

// [testbench/bfpd_core_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Processor core side: store pulses and load/access levels
module bfpd_core_model (
  input  wire logic i_clk,
  output var logic  o_store_program,
  output var logic  o_load_program_instruction,
  output var logic  o_rww_access
);
  initial begin
    o_store_program = 1'b0;
    o_load_program_instruction = 1'b0;
    o_rww_access = 1'b0;
  end
  // One-cycle store, launched right after an edge
  task pulse();
    o_store_program <= 1'b1;
    @(posedge i_clk);
    o_store_program <= 1'b0;
  endtask
  // Load and access are levels held until changed
  task drive(input logic ld, input logic ac);
    o_load_program_instruction <= ld;
    o_rww_access <= ac;
  endtask
endmodule
`default_nettype wire

// [testbench/bfpd_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module bfpd_top_tb;
  import bfpd_pkg::*;
  localparam int PROG = 2;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [1:0]  bss = 2'h3;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, d;
  logic        hready, st, ld, ac, bhi, boot, no_read_while_write_region, busy, blk;
  logic        ce = 1'b1;
  logic        boot64, nrww64, busy64;
  logic [9:0]  page, page64;
  logic [6:0]  word;
  logic [3:0]  stb;
  logic [16:0] pcs [9] = '{17'h1EFFF, 17'h1F000, 17'h1F7FF, 17'h1F800,
    17'h1FBFF, 17'h1FC00, 17'h1FDFF, 17'h1FE00, 17'h00081};
  logic [16:0] bs [4] = '{BOOT128_SZ0, BOOT128_SZ1, BOOT128_SZ2, BOOT128_SZ3};
  logic [16:0] bs64 [4] = '{BOOT64_SZ0, BOOT64_SZ1, BOOT64_SZ2, BOOT64_SZ3};
  int          errors = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #4 i_clk = ~i_clk;
  bfpd_top #(.VARIANT(VAR_128K), .PROG_CYC(PROG)) bfpd_top_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_boot_size_select(bss), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .i_store_program(st),
    .i_load_program_instruction(ld), .i_rww_access(ac),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
    .o_page_select(page), .o_word_select(word), .o_byte_high(bhi),
    .o_in_boot(boot), .o_in_no_read_while_write_region(no_read_while_write_region), .o_region_busy_flag(busy),
    .o_rww_blocked(blk), .o_erase_stb(stb[3]), .o_write_stb(stb[2]),
    .o_fill_stb(stb[1]), .o_lock_stb(stb[0]));
  // Small variant on the same bus; only its decode and busy are compared
  bfpd_top #(.VARIANT(VAR_64K), .PROG_CYC(PROG)) bfpd_top_small_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce),
    .i_boot_size_select(bss), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .i_store_program(st),
    .i_load_program_instruction(ld), .i_rww_access(ac),
    .o_hrdata(), .o_hreadyout(), .o_hresp(),
    .o_page_select(page64), .o_word_select(), .o_byte_high(),
    .o_in_boot(boot64), .o_in_no_read_while_write_region(nrww64),
    .o_region_busy_flag(busy64), .o_rww_blocked(), .o_erase_stb(),
    .o_write_stb(), .o_fill_stb(), .o_lock_stb());
  bfpd_core_model bfpd_core_model_i (.i_clk(i_clk), .o_store_program(st),
    .o_load_program_instruction(ld), .o_rww_access(ac));
  task close_out();
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Hang guard, far above the length of the sequence
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  // Single AHB-Lite word transfer, waits on hready in both phases
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= HSIZE_WORD;
    do @(posedge i_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge i_clk); while (hready !== 1'b1);
    d = hrdata;
  endtask
  // Word address to extension bits and pointer; b is the byte bit
  task setp(input logic [16:0] pc, input logic b);
    ahb(1'b1, REG_EXT, {30'h0, pc[16:15]});
    ahb(1'b1, REG_POINTER, {16'h0, pc[14:0], b});
  endtask
  // Command write, optional delay, then one store; e = expected strobes
  task cmd(input logic [4:0] c, input logic [3:0] e, input int gap);
    ahb(1'b1, REG_CMD, {27'h0, c});
    repeat (gap) @(posedge i_clk);
    fork
      bfpd_core_model_i.pulse();
      begin
        #2;
        chk("strobes", {28'h0, e}, {28'h0, stb});
      end
    join
    #1;
  endtask
  initial begin
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    ahb(1'b0, REG_POINTER, 32'h0);
    chk("pointer", 32'h0, d);
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h0, d);
    ahb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, d);
    ahb(1'b1, REG_POINTER, 32'hFFFFFFFF);
    ahb(1'b0, REG_POINTER, 32'h0);
    chk("pointer", 32'h0000FFFF, d);
    // A frozen block must ignore a write
    ce <= 1'b0;
    ahb(1'b1, REG_POINTER, 32'h00001234);
    ce <= 1'b1;
    ahb(1'b0, REG_POINTER, 32'h0);
    chk("frozen pointer", 32'h0000FFFF, d);
    // Every boot size against addresses either side of each boundary
    for (int s = 0; s < 4; s++) begin
      bss <= s[1:0];
      repeat (4) @(posedge i_clk);
      for (int k = 0; k < 9; k++) begin
        setp(pcs[k], 1'b0);
        #1;
        chk("page", {22'h0, pcs[k][16:7]}, {22'h0, page});
        chk("word", {25'h0, pcs[k][6:0]}, {25'h0, word});
        chk("boot", {31'h0, {pcs[k][16:7], 7'h0} >= bs[s]},
          {31'h0, boot});
        chk("no_read_while_write_region", {31'h0, pcs[k][16:7] >= 10'h3E0}, {31'h0, no_read_while_write_region});
        // Low 16 bits of the first eight addresses are the small part's boundaries
        chk("page64", {23'h0, pcs[k][15:7]}, {22'h0, page64});
        chk("boot64", {31'h0, {pcs[k][15:7], 7'h0} >= bs64[s]},
          {31'h0, boot64});
        chk("nrww64", {31'h0, pcs[k][15:7] >= 9'h1E0},
          {31'h0, nrww64});
      end
    end
    setp(17'h00081, 1'b1);
    bfpd_core_model_i.drive(1'b1, 1'b0);
    @(posedge i_clk);
    chk("byte_high", 32'h1, {31'h0, bhi});
    bfpd_core_model_i.drive(1'b0, 1'b0);
    setp(17'h0, 1'b0);
    cmd(CMD_ERASE, 4'b1000, 0);
    chk("busy", 32'h1, {31'h0, busy});
    chk("busy64", 32'h1, {31'h0, busy64});
    bfpd_core_model_i.drive(1'b0, 1'b1);
    @(posedge i_clk);
    chk("blocked", 32'h1, {31'h0, blk});
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("status busy", 32'h1, {31'h0, d[ST_BUSY]});
    repeat (PROG + 2) @(posedge i_clk);
    cmd(CMD_REEN, 4'b0000, 0);
    chk("busy", 32'h0, {31'h0, busy});
    cmd(5'h07, 4'b0000, 0);
    cmd(CMD_FILL, 4'b0010, 0);
    cmd(CMD_LOCK, 4'b0001, 0);
    cmd(CMD_WRITE, 4'b0100, 0);
    chk("busy", 32'h1, {31'h0, busy});
    repeat (PROG + 2) @(posedge i_clk);
    cmd(CMD_FILL, 4'b0010, 0);
    chk("busy", 32'h0, {31'h0, busy});
    // Arm window is four cycles; a later store must do nothing
    cmd(CMD_FILL, 4'b0000, 6);
    setp(17'h1F800, 1'b0);
    cmd(CMD_ERASE, 4'b1000, 0);
    chk("busy", 32'h0, {31'h0, busy});
    chk("busy64", 32'h0, {31'h0, busy64});
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("status no_read_while_write_region", 32'h1, {31'h0, d[ST_NO_READ_WHILE_WRITE_REGION]});
    bfpd_core_model_i.drive(1'b0, 1'b0);
    repeat (PROG + 2) @(posedge i_clk);
    close_out();
  end
endmodule
`default_nettype wire
